// ---- host_cpu_access_port_regs.svh ----
`ifndef HOST_CPU_ACCESS_PORT_REGS_SVH
`define HOST_CPU_ACCESS_PORT_REGS_SVH

// byte-address bit that routes an access to sdram instead of the registers
`define HCAP_SDRAM_BIT     24
// serial frame layout, counted in bits already transferred
`define HCAP_SPI_BITS      7'h48
`define HCAP_SPI_HDR_END   7'h20
`define HCAP_SPI_RDST_IDX  7'h27
`define HCAP_SPI_DATA_END  7'h40
`define HCAP_SPI_OP_HI     30
`define HCAP_SPI_OP_LO     29
`define HCAP_SPI_BE_HI     28
`define HCAP_SPI_BE_LO     25
`define HCAP_SPI_AD_HI     23
// serial opcodes
`define HCAP_OP_WRITE      2'h1
`define HCAP_OP_READ       2'h2
// byte lanes
`define HCAP_BE_ALL        4'hF
`define HCAP_BE_NONE       4'h0
`define HCAP_ALIGN32       2'h0

`endif

// ---- host_cpu_access_port_pkg.sv ----
package host_cpu_access_port_pkg;

    typedef struct packed {
        logic        write;
        logic        sdram;
        logic [24:0] addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } access_s;

    typedef struct packed {
        logic        accept;
        logic        rd_valid;
        logic [31:0] rd_data;
        logic        wr_done;
    } target_rsp_s;

    typedef enum logic [1:0] {
        P_IDLE,
        P_RDWAIT,
        P_DONE
    } par_state_e;

endpackage

// ---- host_cpu_access_port.sv ----
`timescale 1ns/100ps
`include "host_cpu_access_port_regs.svh"
// Functional notes
// - decode each access as register or sdram, forward it, return read data
// - strap high at reset release selects the parallel bus
// - strap low selects serial slave; shared pins reused, others disabled
// - width pin high gives 32 bit bus, low gives 16 bit bus
// - no bursts; one chip-select assertion is exactly one access
// - bytes within a word are big-endian
// - ready goes low only once write is stored or read data driven
// - host drops select after ready, then device releases ready
// - writes are posted and answered with ready at once
// - next access waits for ready until posted write has finished
// - 32 bit mode: four byte enables replace the two low address bits
// - 16 bit mode: byte enables 0 and 1 replace address bit 0
// - sdram writes touch only enabled bytes
// - register writes are full width; host enables every byte
// - 32 bit mode ignores address bit 1, word aligned
// - 16 bit mode uses address bit 1, halfword aligned
// - reads return a full bus word; host keeps enables high
// - serial mode is a four-wire slave on a master-gated clock
// - clock invert strap sets serial clock polarity
// - clock phase strap picks sample or update on first transition
// - serial mode aligns every access to 32 bits; writes keep the frame's byte enables
module host_cpu_access_port
    import host_cpu_access_port_pkg::*;
(
    // clock, reset, enable
    input  wire logic                                  i_clk,
    input  wire logic                                  i_reset_n,
    input  wire logic                                  i_clk_en,
    // straps
    input  wire logic                                  i_host_port_select,
    input  wire logic                                  i_bus_width_select,
    // host pins
    input  wire logic                                  i_host_chip_select_n,
    input  wire logic                                  i_host_read_write,
    input  wire logic [24:1]                           i_host_address,
    input  wire logic [3:0]                            i_host_byte_enable_n,
    input  wire logic [31:0]                           i_host_data,
    output logic      [31:0]                           o_host_data,
    output logic      [31:0]                           o_host_data_oe,
    output logic                                       o_host_ready_n,
    // target side
    output logic                                       o_req_valid,
    output host_cpu_access_port_pkg::access_s          o_req,
    input  wire host_cpu_access_port_pkg::target_rsp_s i_rsp
);
    import host_cpu_access_port_pkg::*;

    logic        mode_taken;
    logic        spi_mode;
    logic        clk_inv;
    logic        clk_phase;
    par_state_e  state;
    logic        rd_wait;
    logic        wr_out;
    logic        busy;
    logic [31:0] rdata;
    logic        rd_ok;
    logic [31:0] pdata;
    logic        par_load;
    logic        spi_load;
    access_s     par_req;
    access_s     spi_req;
    // serial side
    logic        sclk_q;
    logic        sel_q;
    logic [6:0]  cnt;
    logic [63:0] sin;
    logic        hdr_taken;
    logic        spi_issued;
    logic [1:0]  cur_op;
    logic [3:0]  cur_be_n;
    logic [23:0] cur_addr;
    logic [1:0]  prev_op;
    logic [3:0]  prev_be_n;
    logic [23:0] prev_addr;
    logic        miso;
    logic        sclk;
    logic        sel_n;
    logic        lead;
    logic        trail;
    logic        sample;
    logic        shift;
    logic [71:0] frame_out;

    // straps are caught on the first enabled edge after reset release
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            mode_taken <= 1'b0;
            spi_mode   <= 1'b0;
            clk_inv    <= 1'b0;
            clk_phase  <= 1'b0;
        end else if (i_clk_en && !mode_taken) begin
            mode_taken <= 1'b1;
            spi_mode   <= !i_host_port_select;
            clk_inv    <= i_host_byte_enable_n[3];
            clk_phase  <= i_host_read_write;
        end
    end

    assign busy = o_req_valid | wr_out | rd_wait;

    // parallel request: address and lanes per bus width
    always_comb begin
        par_req.write = !i_host_read_write;
        par_req.sdram = i_host_address[`HCAP_SDRAM_BIT];
        if (i_bus_width_select) begin
            par_req.addr  = {i_host_address[24:2], `HCAP_ALIGN32};
            par_req.be    = ~i_host_byte_enable_n;
            par_req.wdata = i_host_data;
        end else begin
            par_req.addr  = {i_host_address, 1'b0};
            // big-endian: the lower halfword address holds the high lanes
            par_req.be    = i_host_address[1] ? {2'h0, ~i_host_byte_enable_n[1:0]}
                                              : {~i_host_byte_enable_n[1:0], 2'h0};
            par_req.wdata = {i_host_data[15:0], i_host_data[15:0]};
        end
        if (!par_req.write) begin
            par_req.be = `HCAP_BE_ALL;
        end
    end

    // a new access waits here while any earlier write is still in flight
    assign par_load = i_clk_en && !spi_mode && mode_taken && state == P_IDLE
                      && !i_host_chip_select_n && !busy;

    // serial request is word aligned; reads enable all four lanes, writes use the frame's enables
    always_comb begin
        spi_req.write = (cur_op == `HCAP_OP_WRITE);
        spi_req.sdram = cur_addr[`HCAP_SDRAM_BIT - 1];
        spi_req.addr  = {cur_addr[23:1], `HCAP_ALIGN32};
        spi_req.be    = spi_req.write ? ~cur_be_n : `HCAP_BE_ALL;
        spi_req.wdata = sin[31:0];
    end

    assign spi_load = i_clk_en && spi_mode && !sel_n && hdr_taken && !spi_issued && !busy
                      && ((cur_op == `HCAP_OP_READ)
                          || (cur_op == `HCAP_OP_WRITE && cnt >= `HCAP_SPI_DATA_END));

    // request register toward the register file or sdram controller
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_req_valid <= 1'b0;
            o_req       <= '0;
        end else if (i_clk_en) begin
            if (par_load) begin
                o_req_valid <= 1'b1;
                o_req       <= par_req;
            end else if (spi_load) begin
                o_req_valid <= 1'b1;
                o_req       <= spi_req;
            end else if (i_rsp.accept) begin
                o_req_valid <= 1'b0;
            end
        end
    end

    // outstanding write and read tracking; a set beats a clear
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wr_out  <= 1'b0;
            rd_wait <= 1'b0;
        end else if (i_clk_en) begin
            if (o_req_valid && i_rsp.accept && o_req.write) begin
                wr_out <= 1'b1;
            end else if (i_rsp.wr_done) begin
                wr_out <= 1'b0;
            end
            if ((par_load && !par_req.write) || (spi_load && !spi_req.write)) begin
                rd_wait <= 1'b1;
            end else if (i_rsp.rd_valid) begin
                rd_wait <= 1'b0;
            end
        end
    end

    // read data capture for the serial status frame; parallel reads use pdata
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rdata <= '0;
            rd_ok <= 1'b0;
        end else if (i_clk_en) begin
            if (rd_wait && i_rsp.rd_valid) begin
                rdata <= i_rsp.rd_data;
                rd_ok <= 1'b1;
            end else if (spi_load) begin
                rd_ok <= 1'b0;
            end
        end
    end

    // parallel handshake
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state          <= P_IDLE;
            o_host_ready_n <= 1'b1;
            pdata          <= '0;
        end else if (i_clk_en) begin
            unique case (state)
                P_IDLE: begin
                    if (par_load && par_req.write) begin
                        state          <= P_DONE;
                        o_host_ready_n <= 1'b0;
                    end else if (par_load) begin
                        state <= P_RDWAIT;
                    end
                end
                P_RDWAIT: begin
                    if (i_rsp.rd_valid) begin
                        // 16 bit reads hand back the halfword named by bit 1
                        pdata <= i_bus_width_select ? i_rsp.rd_data
                               : o_req.addr[1] ? {16'h0000, i_rsp.rd_data[15:0]}
                                               : {16'h0000, i_rsp.rd_data[31:16]};
                        state          <= P_DONE;
                        o_host_ready_n <= 1'b0;
                    end
                end
                P_DONE: begin
                    // held until select rises, so one select gives one access
                    if (i_host_chip_select_n) begin
                        state          <= P_IDLE;
                        o_host_ready_n <= 1'b1;
                    end
                end
            endcase
        end
    end

    // serial pins borrow the byte-enable inputs and data bit 0
    assign sclk   = i_host_byte_enable_n[0];
    assign sel_n  = i_host_byte_enable_n[2];
    // the leading edge leaves the idle level set by the invert strap
    assign lead   = clk_inv ? (sclk_q && !sclk) : (!sclk_q && sclk);
    assign trail  = clk_inv ? (!sclk_q && sclk) : (sclk_q && !sclk);
    assign sample = spi_mode && !sel_n && (clk_phase ? trail : lead);
    assign shift  = spi_mode && !sel_n && (clk_phase ? lead : trail);

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sclk_q <= 1'b0;
            sel_q  <= 1'b1;
        end else if (i_clk_en) begin
            sclk_q <= sclk;
            sel_q  <= sel_n;
        end
    end

    // input shifter freezes once address and data are in
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cnt <= '0;
            sin <= '0;
        end else if (i_clk_en) begin
            if (!spi_mode || sel_n) begin
                cnt <= '0;
            end else if (sample && cnt < `HCAP_SPI_BITS) begin
                cnt <= cnt + 7'h01;
                if (cnt < `HCAP_SPI_DATA_END) begin
                    sin <= {sin[62:0], i_host_byte_enable_n[1]};
                end
            end
        end
    end

    // header capture, issue tracking and previous-access echo
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            hdr_taken  <= 1'b0;
            spi_issued <= 1'b0;
            cur_op     <= '0;
            cur_be_n   <= `HCAP_BE_ALL;
            cur_addr   <= '0;
            prev_op    <= '0;
            prev_be_n  <= `HCAP_BE_ALL;
            prev_addr  <= '0;
        end else if (i_clk_en) begin
            if (!spi_mode || sel_n) begin
                if (hdr_taken) begin
                    prev_op   <= cur_op;
                    prev_be_n <= cur_be_n;
                    prev_addr <= cur_addr;
                end
                hdr_taken  <= 1'b0;
                spi_issued <= 1'b0;
            end else begin
                if (!hdr_taken && cnt == `HCAP_SPI_HDR_END) begin
                    hdr_taken <= 1'b1;
                    cur_op    <= sin[`HCAP_SPI_OP_HI:`HCAP_SPI_OP_LO];
                    cur_be_n  <= sin[`HCAP_SPI_BE_HI:`HCAP_SPI_BE_LO];
                    cur_addr  <= sin[`HCAP_SPI_AD_HI:0];
                end
                if (spi_load) begin
                    spi_issued <= 1'b1;
                end
            end
        end
    end

    // status: a read reports its data, a write reports that nothing is in flight
    assign frame_out = {1'b0, prev_op, prev_be_n, 1'b0, prev_addr,
                        (cur_op == `HCAP_OP_READ) ? {7'h00, rd_ok, rdata}
                                                  : {32'h0000_0000, 7'h00, spi_issued && !busy}};

    // first bit is presented as select falls so phase 0 can sample at once
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            miso <= 1'b0;
        end else if (i_clk_en) begin
            if (spi_mode && sel_q && !sel_n) begin
                miso <= frame_out[71];
            end else if (shift && cnt < `HCAP_SPI_BITS) begin
                miso <= frame_out[7'd71 - cnt];
            end
        end
    end

    // pin drive: parallel data only while answering a read
    always_comb begin
        o_host_data    = pdata;
        o_host_data_oe = '0;
        if (spi_mode) begin
            o_host_data       = {31'h0000_0000, miso};
            o_host_data_oe[0] = !sel_n;
        end else if (state == P_DONE && i_host_read_write) begin
            o_host_data_oe = i_bus_width_select ? 32'hFFFF_FFFF : 32'h0000_FFFF;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    sequence s_rd_answer;
        state == P_RDWAIT && i_rsp.rd_valid && i_clk_en;
    endsequence

    sequence s_release;
        !o_host_ready_n && i_host_chip_select_n && i_clk_en;
    endsequence

    AST_READ_READY: assert property (s_release or s_rd_answer |=> 1'b1 ##0
        (o_host_ready_n || state == P_DONE))
        else $error("ready low outside done state");
    AST_READ_DATA: assert property (s_rd_answer ##1 (!spi_mode && i_host_read_write)
        |-> !o_host_ready_n && o_host_data_oe[0])
        else $error("read answered without driving data");
    AST_READY_RELEASE: assert property (s_release |=> o_host_ready_n && state == P_IDLE)
        else $error("ready not released after select rose");
    AST_ONE_ACCESS: assert property (state == P_DONE && !i_host_chip_select_n |=> state == P_DONE)
        else $error("second access within one select");
    AST_POSTED: assert property (par_load && par_req.write |=> !o_host_ready_n && o_req_valid)
        else $error("write not posted at once");
    AST_WAIT_WRITE: assert property (state == P_IDLE && wr_out && !spi_mode |=> o_host_ready_n)
        else $error("ready given while write pending");
    AST_ALIGN32: assert property (par_load && i_bus_width_select |=> o_req.addr[1:0] == 2'h0)
        else $error("32 bit access not word aligned");
    AST_ALIGN16: assert property (par_load && !i_bus_width_select
        |=> o_req.addr[0] == 1'b0 && o_req.addr[1] == $past(i_host_address[1]))
        else $error("16 bit address bit 1 lost");
    AST_ENDIAN16: assert property (par_load && !i_bus_width_select && par_req.write
        && !i_host_address[1] |=> o_req.be[1:0] == 2'h0)
        else $error("low halfword address used low lanes");
    AST_SPI_WORD: assert property (spi_load |=> o_req.addr[1:0] == 2'h0
        && (o_req.write || o_req.be == 4'hF))
        else $error("serial access not a full word");
    AST_SPI_QUIET: assert property (spi_mode |-> o_host_ready_n && o_host_data_oe[31:1] == '0)
        else $error("parallel pins active in serial mode");

endmodule // host_cpu_access_port

// ---- host_cpu_master_model.sv ----
`timescale 1ns/100ps
module host_cpu_master_model (
    // clock
    input  wire logic        i_clk,
    // pins toward the device
    output logic             o_cs_n,
    output logic             o_rw,
    output logic [24:1]      o_addr,
    output logic [3:0]       o_be_n,
    output logic [31:0]      o_data,
    // device answers
    input  wire logic        i_ready_n,
    input  wire logic [31:0] i_rdata
);
    logic inv_s;
    logic ph_s;

    initial begin
        inv_s  = 1'b0;
        ph_s   = 1'b0;
        o_cs_n = 1'b1;
        o_rw   = 1'b1;
        o_addr = '0;
        o_be_n = 4'hF;
        o_data = '0;
    end

    // straps seen at reset release; shared pins park at idle levels
    task automatic strap(input logic inv, input logic ph);
        inv_s  = inv;
        ph_s   = ph;
        o_be_n = {inv, 1'b1, 1'b1, inv};
        o_rw   = ph;
    endtask

    task automatic par(input logic wr, input logic [24:1] a, input logic [3:0] ben,
                       input logic [31:0] d, output logic ok);
        int n;
        n = 0;
        @(posedge i_clk);
        #1;
        o_cs_n = 1'b0;
        o_rw   = ~wr;
        o_addr = a;
        o_be_n = wr ? ben : 4'hF;
        o_data = d;
        do begin
            @(posedge i_clk);
            #1;
            n++;
        end while (i_ready_n !== 1'b0 && n < 400);
        o_cs_n = 1'b1;
        o_be_n = 4'hF;
        o_data = ~d;
        while (i_ready_n !== 1'b1 && n < 400) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        ok = (n < 400);
    endtask

    // clock leaves the strap's idle level first; phase 1 updates data there, phase 0 samples there
    task automatic spi(input logic [71:0] tx, output logic [71:0] rx);
        @(posedge i_clk);
        #1;
        o_be_n[2] = 1'b0;
        for (int k = 71; k >= 0; k--) begin
            @(posedge i_clk);
            #1;
            if (ph_s) o_be_n[0] = ~inv_s;
            o_be_n[1] = tx[k];
            repeat (3) @(posedge i_clk);
            #1;
            o_be_n[0] = ph_s ? inv_s : ~inv_s;
            rx[k] = i_rdata[0];
            repeat (4) @(posedge i_clk);
            #1;
            o_be_n[0] = inv_s;
        end
        @(posedge i_clk);
        #1;
        o_be_n[2] = 1'b1;
        o_be_n[1] = ~o_be_n[1];
        repeat (4) @(posedge i_clk);
    endtask
endmodule // host_cpu_master_model

// ---- host_cpu_access_port_test.sv ----
`timescale 1ns/100ps
module host_cpu_access_port_test;
    import host_cpu_access_port_pkg::*;
    localparam int WR_LAT = 20;
    localparam int LIMIT  = 20000;
    logic        clk;
    logic        reset_n;
    logic        port_sel;
    logic        width32;
    logic        cs_n;
    logic        rw;
    logic [24:1] addr;
    logic [3:0]  be_n;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic [31:0] oe;
    logic        ready_n;
    logic        req_valid;
    logic        rd_now;
    logic        prev_rdy;
    access_s     req;
    target_rsp_s rsp;
    access_s     req_q[$];
    logic [31:0] dat_q[$];
    logic [31:0] msk_q[$];
    logic [71:0] rx;
    int          error_cnt;
    int          checks_done;
    int          cyc;
    int          wcnt;
    int          wr_cnt;
    int          done_cnt;
    int          wr_need;

    host_cpu_access_port dut_u (
        .i_clk(clk), .i_reset_n(reset_n), .i_clk_en(1'b1),
        .i_host_port_select(port_sel), .i_bus_width_select(width32),
        .i_host_chip_select_n(cs_n), .i_host_read_write(rw), .i_host_address(addr),
        .i_host_byte_enable_n(be_n), .i_host_data(wdat), .o_host_data(rdat),
        .o_host_data_oe(oe), .o_host_ready_n(ready_n), .o_req_valid(req_valid),
        .o_req(req), .i_rsp(rsp)
    );
    host_cpu_master_model host_u (
        .i_clk(clk), .o_cs_n(cs_n), .o_rw(rw), .o_addr(addr), .o_be_n(be_n),
        .o_data(wdat), .i_ready_n(ready_n), .i_rdata(rdat)
    );

    initial clk = 1'b0;
    always #2.5 clk = ~clk;

    function automatic logic [31:0] rd_word(input logic [24:0] a);
        return {7'h00, a} ^ 32'h5A3C96E1;
    endfunction

    task automatic note(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask
    task automatic cmp_req(input access_s e);
        access_s g;
        g = req;
        if (!e.write) g.wdata = e.wdata;
        note(g === e, "request fields differ");
    endtask
    task automatic cmp_word(input logic [31:0] g, input logic [31:0] e);
        note(g === e, "data word differs");
    endtask
    task automatic end_sim();
        note(req_q.size() == 0 && dat_q.size() == 0, "expected results never seen");
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // target: accepts after one cycle, read word next cycle, write done late
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rsp <= '0;
            wcnt <= 0;
        end else begin
            rsp.accept   <= req_valid && !rsp.accept;
            rsp.rd_valid <= req_valid && rsp.accept && !req.write;
            rsp.rd_data  <= rd_word(req.addr);
            rsp.wr_done  <= (wcnt == 1);
            if (req_valid && rsp.accept && req.write) wcnt <= WR_LAT;
            else if (wcnt > 0) wcnt <= wcnt - 1;
        end
    end

    always @(posedge clk) begin
        logic [31:0] m;
        cyc++;
        if (rsp.wr_done === 1'b1) done_cnt++;
        if (req_valid === 1'b1 && rsp.accept === 1'b1) begin
            if (req_q.size() == 0) note(1'b0, "unexpected request");
            else cmp_req(req_q.pop_front());
        end
        if (prev_rdy === 1'b1 && ready_n === 1'b0) begin
            note(done_cnt >= wr_need, "ready before earlier write finished");
            if (rd_now && dat_q.size() > 0) begin
                m = msk_q.pop_front();
                cmp_word(rdat & m, dat_q.pop_front());
                cmp_word(oe & m, m);
            end
        end
        prev_rdy = ready_n;
        if (cyc == LIMIT) begin
            note(1'b0, "timeout");
            end_sim();
        end
    end

    task automatic bus(input logic wr, input logic [24:1] a, input logic [3:0] ben, input logic [31:0] d);
        access_s     e;
        logic [31:0] w;
        logic        ok;
        e.write = wr;
        e.sdram = a[24];
        e.addr  = {a, 1'b0};
        e.be    = wr ? ~ben : 4'hF;
        e.wdata = d;
        if (width32) e.addr[1] = 1'b0;
        else begin
            e.be    = !wr ? 4'hF : (a[1] ? {2'b00, ~ben[1:0]} : {~ben[1:0], 2'b00});
            e.wdata = {d[15:0], d[15:0]};
        end
        req_q.push_back(e);
        w = rd_word(e.addr);
        if (!wr) begin
            dat_q.push_back(width32 ? w : {16'h0000, a[1] ? w[15:0] : w[31:16]});
            msk_q.push_back(width32 ? 32'hFFFFFFFF : 32'h0000FFFF);
        end
        rd_now  = !wr;
        wr_need = wr_cnt;
        if (wr) wr_cnt++;
        host_u.par(wr, a, ben, d, ok);
        if (!ok) note(1'b0, "no ready from device");
    endtask

    task automatic do_reset(input logic par_mode);
        port_sel = par_mode;
        reset_n  = 1'b0;
        repeat (16) @(posedge clk);
        #1;
        reset_n = 1'b1;
        repeat (2) @(posedge clk);
    endtask

    initial begin
        logic [24:1] a;
        logic [3:0]  b;
        error_cnt = 0;
        checks_done = 0;
        cyc = 0;
        wr_cnt = 0;
        done_cnt = 0;
        wr_need = 0;
        rd_now = 1'b0;
        prev_rdy = 1'b1;
        width32 = 1'b1;
        do_reset(1'b1);
        void'($urandom(32'h8A2D52AD));
        bus(1'b1, 24'h800013, 4'hB, 32'h11223344);
        bus(1'b0, 24'h800013, 4'hF, 32'h00000000);
        bus(1'b1, 24'h000040, 4'h0, 32'hCAFE0001);
        bus(1'b1, 24'h800020, 4'h3, 32'hA1B2C3D4);
        bus(1'b0, 24'h000040, 4'hF, 32'h00000000);
        $display("test 32 bit directed done");
        for (int i = 0; i < 8; i++) begin
            a = 24'($urandom());
            b = a[24] ? 4'($urandom()) : 4'h0;
            bus(1'b1, a, b, $urandom());
            bus(1'b0, a, 4'hF, 32'h00000000);
        end
        $display("test 32 bit random done");
        width32 = 1'b0;
        bus(1'b1, 24'h800021, 4'hE, 32'h0000BEEF);
        bus(1'b0, 24'h800021, 4'hF, 32'h00000000);
        bus(1'b1, 24'h000030, 4'h0, 32'h00001234);
        bus(1'b0, 24'h800030, 4'hF, 32'h00000000);
        $display("test 16 bit done");
        for (int m = 0; m < 2; m++) begin
            host_u.strap(m[0], m[0]);
            do_reset(1'b0);
            a = 24'h800104;
            req_q.push_back('{1'b1, 1'b1, {a[24:2], 2'b00}, 4'hF, 32'h89ABCDEF});
            host_u.spi({1'b0, 2'b01, 4'h0, 1'b0, a, 32'h89ABCDEF, 8'h00}, rx);
            note(rx[0] === 1'b1, "serial write status");
            req_q.push_back('{1'b0, 1'b1, {a[24:2], 2'b00}, 4'hF, 32'h00000000});
            host_u.spi({1'b0, 2'b10, 4'hF, 1'b0, a, 32'h00000000, 8'h00}, rx);
            cmp_word({26'h0, rx[70:65]}, {26'h0, 2'b01, 4'h0});
            cmp_word({8'h00, rx[63:40]}, {8'h00, a});
            note(rx[32] === 1'b1, "serial read status");
            cmp_word(rx[31:0], rd_word({a[24:2], 2'b00}));
            note(ready_n === 1'b1, "ready moved in serial mode");
            $display("test serial mode %0d done", m);
        end
        end_sim();
    end
endmodule // host_cpu_access_port_test
